// ===== src/ric_pkg.sv
/*
  Constants, types and helpers for the reset and interrupt control block.
  Assumes a single 25 MHz core clock and a 16-bit register port.
*/
package ric_pkg;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 3;
  localparam int          DATA_W          = 16;
  localparam logic [2:0]  OFS_LATCHES     = 3'h0;
  localparam logic [2:0]  OFS_ENABLES     = 3'h1;
  localparam logic [2:0]  OFS_WDOG_CTRL   = 3'h2;
  localparam logic [2:0]  OFS_SYSCLK_CTRL = 3'h3;
  localparam logic [2:0]  OFS_SELECTOR    = 3'h4;
  localparam logic [2:0]  OFS_CAUSE       = 3'h5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_IMF        = 0;
  localparam int BIT_TRAP_OUT   = 0;
  localparam int BIT_WDOG_OUT   = 1;
  localparam int BIT_RAM_TRAP   = 2;
  localparam int BIT_WDOG_EN    = 3;
  localparam int BIT_EXT0_PIN   = 4;
  localparam int BIT_XEN        = 0;
  localparam int BIT_XTEN       = 1;
  localparam int BIT_SYSCK      = 2;
  localparam int BIT_L11_SEL    = 0;
  localparam int CAUSE_PIN      = 0;
  localparam int CAUSE_TRAP     = 1;
  localparam int CAUSE_WDOG     = 2;
  localparam int CAUSE_CLOCK    = 3;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [4:0]  WDOG_CTRL_RESET = 5'h0b;
  localparam logic [2:0]  SYSCLK_RESET    = 3'h1;
  localparam logic [15:0] RESET_VECTOR    = 16'hfffe;

  // ----------------------------------------------------------------
  // Sources, areas and counts
  // ----------------------------------------------------------------
  localparam int          NUM_LEVELS       = 16;
  localparam int          SRC_SOFT         = 1;
  localparam int          SRC_TRAP         = 2;
  localparam int          SRC_WDOG         = 3;
  localparam int          SRC_EXT0         = 4;
  localparam int          SRC_L11          = 11;
  localparam int          IMF_STACK_DEPTH  = 8;
  localparam logic [15:0] SFR_FIRST        = 16'h0000;
  localparam logic [15:0] SFR_LAST         = 16'h003f;
  localparam logic [15:0] RAM_FIRST        = 16'h0040;
  localparam logic [15:0] RAM_LAST         = 16'h013f;
  localparam int          MALF_MAX_CYCLES  = 24;
  localparam logic [4:0]  MALF_HOLD_CYCLES = 5'h0c;

  typedef enum logic [1:0] {
    RIC_HELD  = 2'b00,
    RIC_FETCH = 2'b01,
    RIC_RUN   = 2'b11
  } ric_state_t;

  function automatic logic [15:0] ric_vector(input logic [3:0] idx);
    ric_vector = RESET_VECTOR - {11'h000, idx, 1'b0};
  endfunction

endpackage

// ===== src/ric_arb_if.sv
/*
  Carrier between the request collector and the priority picker.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/10ps
interface ric_arb_if;
  logic [15:0] pending;
  logic        grantValid;
  logic [3:0]  grantIdx;
  modport requester (output pending, input grantValid, input grantIdx);
  modport arbiter   (input pending, output grantValid, output grantIdx);
endinterface

// ===== src/ric_priority_pick.sv
/*
  Fixed priority picker: the lowest pending level index wins.
  Assumes pending bit 0 is never used and the result is sampled by a register.
*/
`timescale 1ns/10ps
module ric_priority_pick import ric_pkg::*; (
  ric_arb_if.arbiter arb
);

  always_comb begin
    arb.grantValid = 1'b0;
    arb.grantIdx   = 4'h0;
    for (int i = NUM_LEVELS - 1; i >= 1; i--) begin
      if (arb.pending[i]) begin
        arb.grantValid = 1'b1;
        arb.grantIdx   = 4'(i);
      end
    end
  end

endmodule // ric_priority_pick

// ===== src/ric_top.sv
/*
  Reset generation and interrupt arbitration for a small 8-bit core.
  Assumes the core, peripherals and register master run on core_clk and
  that only the reset pin arrives from outside this clock domain.
*/
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/10ps

module ric_top import ric_pkg::*; (
  input  wire  logic               core_clk,
  input  wire  logic               reset,
  input  wire  logic               resetPinN,
  input  wire  logic [ADDR_W-1:0]  regAddr,
  input  wire  logic [DATA_W-1:0]  regWdata,
  input  wire  logic               regWr,
  input  wire  logic               regRd,
  output logic       [DATA_W-1:0]  regRdata,
  input  wire  logic               fetchValid,
  input  wire  logic [15:0]        fetchAddr,
  input  wire  logic               instrBoundary,
  input  wire  logic               softwareIrq,
  input  wire  logic               illegalOpcodeIrq,
  input  wire  logic               returnFromIrq,
  input  wire  logic               wdogOverflow,
  input  wire  logic [15:4]        periphIrq,
  input  wire  logic               extIrqThree,
  output logic                     coreReset,
  output logic                     vectorFetch,
  output logic                     irqTake,
  output logic       [15:0]        vectorAddr,
  output logic                     prescalerClear,
  output logic                     watchdogEnable,
  output logic                     highOscEnable,
  output logic                     lowOscEnable,
  output logic                     sysClkSelect
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ric_state_t        state_reg;
  logic [1:0]        pinSync_reg;
  logic [4:0]        malfCount_reg;
  logic              coreReset_reg;
  logic              coreReset_next;
  logic              vectorFetch_reg;
  logic              irqTake_reg;
  logic [15:0]       vectorAddr_reg;
  logic [DATA_W-1:0] regRdata_reg;
  logic [15:0]       latches_reg;
  logic [15:0]       latches_next;
  logic [15:4]       sourceEnable_reg;
  logic              imf_reg;
  logic [IMF_STACK_DEPTH-1:0] imfStack_reg;
  logic [4:0]        wdogCtrl_reg;
  logic [2:0]        sysClk_reg;
  logic              l11Select_reg;
  logic [3:0]        cause_reg;
  logic              anyReset;
  logic              extResetActive;
  logic              trapHit;
  logic              trapReset;
  logic              wdogReset;
  logic              clkBadWrite;
  logic              malfDetect;
  logic              acceptNow;
  logic [15:0]       setVec;
  logic [15:0]       clrVec;
  logic [15:0]       grantOneHot;
  logic              xenClear;
  logic              xtenClear;

  ric_arb_if arbBus ();

  ric_priority_pick u_pick (
    .arb (arbBus.arbiter)
  );

  function automatic logic in_area(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
    in_area = (a >= lo) && (a <= hi);
  endfunction

  assign anyReset       = reset | coreReset_reg;
  assign extResetActive = ~pinSync_reg[1];

  // ----------------------------------------------------------------
  // Reset causes
  // ----------------------------------------------------------------
  // pin synchroniser
  // Short pin pulses still reset; the twelve-clock hold is the agent's duty
  // Starts at the pin's idle level, so no false pin cause follows reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pinSync_reg <= 2'b11;
    end else begin
      pinSync_reg <= {pinSync_reg[0], resetPinN};
    end
  end

  assign trapHit = fetchValid && (state_reg == RIC_RUN) &&
                   (in_area(fetchAddr, SFR_FIRST, SFR_LAST) ||
                    (wdogCtrl_reg[BIT_RAM_TRAP] && in_area(fetchAddr, RAM_FIRST, RAM_LAST)));
  assign trapReset = trapHit && wdogCtrl_reg[BIT_TRAP_OUT];
  assign wdogReset = wdogOverflow && wdogCtrl_reg[BIT_WDOG_OUT];

  assign xenClear    = sysClk_reg[BIT_XEN] && !regWdata[BIT_XEN];
  assign xtenClear   = sysClk_reg[BIT_XTEN] && !regWdata[BIT_XTEN];
  assign clkBadWrite = regWr && (regAddr == OFS_SYSCLK_CTRL) &&
                       ((xenClear && xtenClear) ||
                        (xenClear && !sysClk_reg[BIT_SYSCK]) ||
                        (xtenClear && sysClk_reg[BIT_SYSCK]));

  assign malfDetect = !coreReset_reg && (trapReset || wdogReset || clkBadWrite);

  assign coreReset_next = extResetActive || (malfCount_reg != 5'h00) || malfDetect;

  // power-up stretch
  // Counter restarts at power-up, so a short internal reset always follows
  always_ff @(posedge core_clk) begin
    if (reset) begin
      malfCount_reg <= MALF_HOLD_CYCLES;
    end else if (malfDetect) begin
      malfCount_reg <= MALF_HOLD_CYCLES;
    end else if (malfCount_reg != 5'h00) begin
      malfCount_reg <= malfCount_reg - 5'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      coreReset_reg <= 1'b1;
    end else begin
      coreReset_reg <= coreReset_next;
    end
  end

  // Cause record survives internal resets; write one to clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cause_reg <= 4'h0;
    end else begin
      cause_reg <= (cause_reg & ~((regWr && regAddr == OFS_CAUSE) ? regWdata[3:0] : 4'h0))
                 | {clkBadWrite, wdogReset, trapReset, extResetActive};
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and vector output
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= RIC_HELD;
    end else if (coreReset_next) begin
      state_reg <= RIC_HELD;
    end else begin
      unique case (state_reg)
        RIC_HELD:  state_reg <= RIC_FETCH;
        RIC_FETCH: state_reg <= RIC_RUN;
        RIC_RUN:   state_reg <= RIC_RUN;
        default:   state_reg <= RIC_HELD;
      endcase
    end
  end

  assign acceptNow = (state_reg == RIC_RUN) && instrBoundary && arbBus.grantValid &&
                     !irqTake_reg && !coreReset_next;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      vectorFetch_reg <= 1'b0;
      irqTake_reg     <= 1'b0;
      vectorAddr_reg  <= RESET_VECTOR;
    end else begin
      vectorFetch_reg <= (state_reg == RIC_HELD) && coreReset_reg && !coreReset_next;
      irqTake_reg     <= acceptNow;
      if (coreReset_next) begin
        vectorAddr_reg <= RESET_VECTOR;
      end else if (acceptNow) begin
        vectorAddr_reg <= ric_vector(arbBus.grantIdx);
      end
    end
  end

  // ----------------------------------------------------------------
  // Request latches
  // ----------------------------------------------------------------
  // trap and watchdog latches
  assign setVec[1:0]         = 2'b00;
  assign setVec[SRC_TRAP]    = trapHit && !wdogCtrl_reg[BIT_TRAP_OUT];
  assign setVec[SRC_WDOG]    = wdogOverflow && !wdogCtrl_reg[BIT_WDOG_OUT];
  assign setVec[10:4]        = periphIrq[10:4];
  assign setVec[SRC_L11]     = l11Select_reg ? extIrqThree : periphIrq[SRC_L11];
  assign setVec[15:12]       = periphIrq[15:12];

  assign grantOneHot = acceptNow ? (16'h0001 << arbBus.grantIdx) : 16'h0000;
  assign clrVec      = grantOneHot | ((regWr && regAddr == OFS_LATCHES) ? ~regWdata : 16'h0000);

  assign latches_next = ((latches_reg & ~clrVec) | setVec) & 16'hfffc;

  always_ff @(posedge core_clk) begin
    if (anyReset) begin
      latches_reg <= 16'h0000;
    end else begin
      latches_reg <= latches_next;
    end
  end

  genvar g;
  generate
    for (g = 4; g < NUM_LEVELS; g++) begin : g_mask
      if (g == SRC_EXT0) begin : g_ext0
        assign arbBus.pending[g] = latches_reg[g] && sourceEnable_reg[g] && imf_reg &&
                                   wdogCtrl_reg[BIT_EXT0_PIN];
      end else begin : g_plain
        assign arbBus.pending[g] = latches_reg[g] && sourceEnable_reg[g] && imf_reg;
      end
    end
  endgenerate
  assign arbBus.pending[0]        = 1'b0;
  assign arbBus.pending[SRC_SOFT] = softwareIrq || illegalOpcodeIrq;
  assign arbBus.pending[3:2]      = latches_reg[3:2];

  // ----------------------------------------------------------------
  // Enables and master enable stack
  // ----------------------------------------------------------------
  // push, clear, restore
  always_ff @(posedge core_clk) begin
    if (anyReset) begin
      imf_reg          <= 1'b0;
      imfStack_reg     <= '0;
      sourceEnable_reg <= '0;
    end else begin
      if (regWr && regAddr == OFS_ENABLES) begin
        sourceEnable_reg <= regWdata[15:4];
      end
      if (acceptNow) begin
        imf_reg      <= 1'b0;
        imfStack_reg <= {imfStack_reg[IMF_STACK_DEPTH-2:0], imf_reg};
      end else if (returnFromIrq) begin
        imf_reg      <= imfStack_reg[0];
        imfStack_reg <= {1'b0, imfStack_reg[IMF_STACK_DEPTH-1:1]};
      end else if (regWr && regAddr == OFS_ENABLES) begin
        imf_reg <= regWdata[BIT_IMF];
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // trap output default
  always_ff @(posedge core_clk) begin
    if (anyReset) begin
      wdogCtrl_reg  <= WDOG_CTRL_RESET;
      l11Select_reg <= 1'b0;
    end else begin
      if (regWr && regAddr == OFS_WDOG_CTRL) begin
        wdogCtrl_reg <= regWdata[4:0];
      end
      if (regWr && regAddr == OFS_SELECTOR) begin
        l11Select_reg <= regWdata[BIT_L11_SEL];
      end
    end
  end

  // Oscillator bits keep running through the reset they triggered
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sysClk_reg <= SYSCLK_RESET;
    end else if (coreReset_reg) begin
      sysClk_reg[BIT_SYSCK] <= 1'b0;
    end else if (regWr && regAddr == OFS_SYSCLK_CTRL && !clkBadWrite) begin
      sysClk_reg <= regWdata[2:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      prescalerClear <= 1'b1;
    end else begin
      prescalerClear <= coreReset_next;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset || !regRd) begin
      regRdata_reg <= '0;
    end else begin
      unique case (regAddr)
        OFS_LATCHES:     regRdata_reg <= latches_reg;
        OFS_ENABLES:     regRdata_reg <= {sourceEnable_reg, 3'h0, imf_reg};
        OFS_WDOG_CTRL:   regRdata_reg <= {11'h000, wdogCtrl_reg};
        OFS_SYSCLK_CTRL: regRdata_reg <= {13'h0000, sysClk_reg};
        OFS_SELECTOR:    regRdata_reg <= {15'h0000, l11Select_reg};
        OFS_CAUSE:       regRdata_reg <= {12'h000, cause_reg};
        default:         regRdata_reg <= '0;
      endcase
    end
  end

  assign regRdata       = regRdata_reg;
  assign coreReset      = coreReset_reg;
  assign vectorFetch    = vectorFetch_reg;
  assign irqTake        = irqTake_reg;
  assign vectorAddr     = vectorAddr_reg;
  assign watchdogEnable = wdogCtrl_reg[BIT_WDOG_EN];
  assign highOscEnable  = sysClk_reg[BIT_XEN];
  assign lowOscEnable   = sysClk_reg[BIT_XTEN];
  assign sysClkSelect   = sysClk_reg[BIT_SYSCK];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_malf_reset_fast: assert property (
    @(posedge core_clk) disable iff (reset)
    malfDetect |=> coreReset_reg && (malfCount_reg == MALF_HOLD_CYCLES))
    else $error("malfunction reset not applied");

  a_powerup_pulse_len: assert property (
    @(posedge core_clk) $fell(reset) |-> coreReset_reg [*8])
    else $error("power-up internal reset too short");

  a_reset_clears_irq: assert property (
    @(posedge core_clk) disable iff (reset)
    coreReset_reg |=> (latches_reg == 16'h0000) && !imf_reg && (sourceEnable_reg == '0))
    else $error("reset left interrupt state set");

  a_release_fetch_vec: assert property (
    @(posedge core_clk) disable iff (reset)
    $fell(coreReset_reg) |-> vectorFetch_reg && (vectorAddr_reg == RESET_VECTOR))
    else $error("no reset vector fetch at release");

  a_trap_to_latch: assert property (
    @(posedge core_clk) disable iff (reset)
    (trapHit && !wdogCtrl_reg[BIT_TRAP_OUT] && !coreReset_reg) |=> latches_reg[SRC_TRAP])
    else $error("trap interrupt not latched");

  a_clock_stop_reset: assert property (
    @(posedge core_clk) disable iff (reset)
    (clkBadWrite && !coreReset_reg) |=> coreReset_reg && $stable(sysClk_reg[1:0]))
    else $error("illegal oscillator stop not caught");

  a_masked_gate: assert property (
    @(posedge core_clk) disable iff (reset)
    (irqTake && vectorAddr_reg < 16'hfff8) |-> $past(imf_reg))
    else $error("maskable taken with master disabled");

  a_accept_clears: assert property (
    @(posedge core_clk) disable iff (reset)
    (acceptNow && arbBus.grantIdx > 4'h1 && !setVec[arbBus.grantIdx])
      |=> !latches_reg[$past(arbBus.grantIdx)])
    else $error("latch kept after acceptance");

  a_accept_masks_imf: assert property (
    @(posedge core_clk) disable iff (reset)
    acceptNow |=> !imf_reg && (imfStack_reg[0] == $past(imf_reg)))
    else $error("master enable not pushed and cleared");

  a_wdog_default_rst: assert property (
    @(posedge core_clk) disable iff (reset)
    coreReset_reg |=> wdogCtrl_reg[BIT_WDOG_OUT] && wdogCtrl_reg[BIT_TRAP_OUT])
    else $error("output selects not defaulted to reset");

endmodule // ric_top

// ===== verif/ric_cpu_model.sv
/*
  Core model: instruction boundaries with stalls, fetches, soft requests, returns.
  Assumes the bench kicks it right after rising core_clk edges.
*/
`timescale 1ns/10ps
module ric_cpu_model (
  input  wire logic        core_clk,
  input  wire logic        coreReset,
  input  wire logic        irqTake,
  input  wire logic [1:0]  swKick,
  input  wire logic        retKick,
  input  wire logic        fetchKick,
  input  wire logic [15:0] fetchTarget,
  output logic             instrBoundary,
  output logic             softwareIrq,
  output logic             illegalOpcodeIrq,
  output logic             returnFromIrq,
  output logic             fetchValid,
  output logic [15:0]      fetchAddr
);
  logic [7:0] tick_reg = 8'h00;
  always @(posedge core_clk) tick_reg <= tick_reg + 8'h01;
  // Every fourth cycle is mid-instruction, so accepts stall
  assign instrBoundary = (coreReset === 1'b0) && (tick_reg[1:0] != 2'h3);
  assign fetchValid    = (coreReset === 1'b0);
  // Idle fetches walk ROM and change every cycle
  assign fetchAddr     = fetchKick ? fetchTarget : {8'h80, tick_reg};
  assign returnFromIrq = retKick;
  initial softwareIrq = 1'b0;
  initial illegalOpcodeIrq = 1'b0;
  always @(posedge core_clk) begin
    if (irqTake === 1'b1) begin
      softwareIrq <= 1'b0;
      illegalOpcodeIrq <= 1'b0;
    end else begin
      softwareIrq <= softwareIrq | swKick[0];
      illegalOpcodeIrq <= illegalOpcodeIrq | swKick[1];
    end
  end
endmodule // ric_cpu_model

// ===== verif/reset_and_interrupt_control_tb_top.sv
/*
  Self-checking bench for ric_top with the core model on its far side.
  Assumes ric_pkg, ric_top and ric_cpu_model are compiled first.
*/
`timescale 1ns/10ps
module reset_and_interrupt_control_tb_top import ric_pkg::*; ;
  logic              core_clk = 1'b0;
  logic              reset = 1'b1;
  logic              resetPinN = 1'b1;
  logic              regWr = 1'b0;
  logic              regRd = 1'b0;
  logic              wdogOverflow = 1'b0;
  logic              extIrqThree = 1'b0;
  logic              retKick = 1'b0;
  logic              fetchKick = 1'b0;
  logic [1:0]        swKick = 2'h0;
  logic [ADDR_W-1:0] regAddr = 3'h0;
  logic [DATA_W-1:0] regWdata = 16'h0000;
  logic [15:0]       fetchTarget = 16'h0000;
  logic [15:4]       periphIrq = 12'h000;
  logic [DATA_W-1:0] regRdata;
  logic [15:0]       vectorAddr, fetchAddr;
  logic              coreReset, vectorFetch, irqTake, prescalerClear, watchdogEnable;
  logic              highOscEnable, lowOscEnable, sysClkSelect, instrBoundary;
  logic              softwareIrq, illegalOpcodeIrq, returnFromIrq, fetchValid;
  logic [31:0]       seed = 32'h0000000d;
  int                failures = 0;
  int                nChecks = 0;
  int                cycles = 0;
  int                a, b;
  logic [15:0]       prep [3] = '{16'h0001, 16'h0003, 16'h0007};
  logic [15:0]       bad [3] = '{16'h0000, 16'h0000, 16'h0005};

  ric_top DUT (.core_clk, .reset, .resetPinN, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .fetchValid, .fetchAddr, .instrBoundary, .softwareIrq, .illegalOpcodeIrq,
    .returnFromIrq, .wdogOverflow, .periphIrq, .extIrqThree, .coreReset, .vectorFetch,
    .irqTake, .vectorAddr, .prescalerClear, .watchdogEnable, .highOscEnable,
    .lowOscEnable, .sysClkSelect);
  ric_cpu_model cpu (.core_clk, .coreReset, .irqTake, .swKick, .retKick, .fetchKick,
    .fetchTarget, .instrBoundary, .softwareIrq, .illegalOpcodeIrq, .returnFromIrq,
    .fetchValid, .fetchAddr);

  always #20 core_clk = ~core_clk;
  // Run needs about 550 cycles; ceiling well above
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  function automatic logic [15:0] vec_of(input int i);
    return 16'hfffe - 16'(2 * i);
  endfunction
  function automatic logic [11:0] bit_of(input int i);
    return 12'h001 << (i - 4);
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (failures == 0 && nChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [2:0] ad, input logic [15:0] d);
    @(posedge core_clk) regWr <= 1'b1;
    regAddr <= ad;
    regWdata <= d;
    @(posedge core_clk) regWr <= 1'b0;
  endtask
  task automatic rchk(input logic [2:0] ad, input logic [15:0] e);
    @(posedge core_clk) regRd <= 1'b1;
    regAddr <= ad;
    @(posedge core_clk) regRd <= 1'b0;
    #1 chk(regRdata, e);
  endtask
  task automatic fire(input logic [11:0] m);
    @(posedge core_clk) periphIrq <= m;
    @(posedge core_clk) periphIrq <= 12'h000;
  endtask
  task automatic retn();
    @(posedge core_clk) retKick <= 1'b1;
    @(posedge core_clk) retKick <= 1'b0;
  endtask
  task automatic fetch(input logic [15:0] ad);
    @(posedge core_clk) fetchKick <= 1'b1;
    fetchTarget <= ad;
    @(posedge core_clk) fetchKick <= 1'b0;
  endtask
  task automatic kick_wdog();
    @(posedge core_clk) wdogOverflow <= 1'b1;
    @(posedge core_clk) wdogOverflow <= 1'b0;
  endtask
  task automatic wait_take(input logic [15:0] v);
    int n;
    n = 0;
    while (irqTake !== 1'b1 && n < 80) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk({15'h0, irqTake}, 16'h0001);
    chk(vectorAddr, v);
  endtask
  task automatic wait_rst(input logic lvl, input int lim);
    int n;
    n = 0;
    while (coreReset !== lvl && n < lim) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk({15'h0, coreReset}, {15'h0, lvl});
  endtask
  task automatic boot();
    wait_rst(1'b0, 60);
    chk({15'h0, vectorFetch}, 16'h0001);
    chk(vectorAddr, RESET_VECTOR);
    cyc(3);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    cyc(12);
    #1 chk({12'h0, coreReset, prescalerClear, watchdogEnable, highOscEnable}, 16'h000f);
    chk(vectorAddr, RESET_VECTOR);
    reset <= 1'b0;
    boot();
    rchk(OFS_LATCHES, 16'h0000);
    rchk(OFS_ENABLES, 16'h0000);
    rchk(OFS_WDOG_CTRL, 16'h000b);
    rchk(OFS_SYSCLK_CTRL, 16'h0001);
    rchk(3'h6, 16'h0000);
    wr(OFS_WDOG_CTRL, 16'h001b);
    wr(OFS_ENABLES, 16'hfff1);
    for (int i = 4; i < 16; i++) begin
      fire(bit_of(i));
      wait_take(vec_of(i));
      rchk(OFS_LATCHES, 16'h0000);
      rchk(OFS_ENABLES, 16'hfff0);
      retn();
      rchk(OFS_ENABLES, 16'hfff1);
    end
    wr(OFS_ENABLES, 16'hfff0);
    fire(12'hfff);
    cyc(6);
    rchk(OFS_LATCHES, 16'hfff0);
    wr(OFS_ENABLES, 16'hfff1);
    for (int i = 4; i < 16; i++) begin
      wait_take(vec_of(i));
      retn();
    end
    for (int k = 0; k < 8; k++) begin
      a = 4 + int'(xs() % 16'h000c);
      b = 4 + int'(xs() % 16'h000c);
      fire(bit_of(a) | bit_of(b));
      wait_take(vec_of(a < b ? a : b));
      retn();
      if (a != b) begin
        wait_take(vec_of(a < b ? b : a));
        retn();
      end
    end
    // Own flag off, then pin enable off: level four stays pending
    for (int k = 0; k < 2; k++) begin
      wr(OFS_WDOG_CTRL, k ? 16'h000b : 16'h001b);
      wr(OFS_ENABLES, k ? 16'hfff1 : 16'hffe1);
      fire(12'h001);
      cyc(6);
      rchk(OFS_LATCHES, 16'h0010);
      wr(OFS_LATCHES, 16'h0000);
      rchk(OFS_LATCHES, 16'h0000);
    end
    wr(OFS_SELECTOR, 16'h0001);
    fire(bit_of(11));
    cyc(6);
    rchk(OFS_LATCHES, 16'h0000);
    @(posedge core_clk) extIrqThree <= 1'b1;
    @(posedge core_clk) extIrqThree <= 1'b0;
    wait_take(16'hffe8);
    retn();
    wr(OFS_SELECTOR, 16'h0000);
    wr(OFS_ENABLES, 16'h0000);
    for (int k = 1; k < 3; k++) begin
      @(posedge core_clk) swKick <= 2'(k);
      @(posedge core_clk) swKick <= 2'h0;
      wait_take(16'hfffc);
    end
    wr(OFS_WDOG_CTRL, 16'h0008);
    kick_wdog();
    wait_take(16'hfff8);
    fetch(16'h0050);
    cyc(6);
    rchk(OFS_LATCHES, 16'h0000);
    fetch(16'h0010);
    wait_take(16'hfffa);
    wr(OFS_WDOG_CTRL, 16'h000c);
    fetch(16'h013f);
    wait_take(16'hfffa);
    wr(OFS_ENABLES, 16'hfff1);
    wr(OFS_WDOG_CTRL, 16'h000b);
    fetch(16'h0020);
    wait_rst(1'b1, 24);
    chk({15'h0, prescalerClear}, 16'h0001);
    boot();
    rchk(OFS_ENABLES, 16'h0000);
    rchk(OFS_CAUSE, 16'h0002);
    wr(OFS_CAUSE, 16'h000f);
    kick_wdog();
    wait_rst(1'b1, 24);
    boot();
    rchk(OFS_CAUSE, 16'h0004);
    for (int k = 0; k < 3; k++) begin
      wr(OFS_CAUSE, 16'h000f);
      wr(OFS_SYSCLK_CTRL, prep[k]);
      wr(OFS_SYSCLK_CTRL, bad[k]);
      wait_rst(1'b1, 24);
      chk({15'h0, highOscEnable}, 16'h0001);
      boot();
      rchk(OFS_CAUSE, 16'h0008);
    end
    chk({14'h0, lowOscEnable, sysClkSelect}, 16'h0002);
    wr(OFS_CAUSE, 16'h000f);
    @(posedge core_clk) resetPinN <= 1'b0;
    cyc(12);
    #1 chk({15'h0, coreReset}, 16'h0001);
    @(posedge core_clk) resetPinN <= 1'b1;
    boot();
    rchk(OFS_CAUSE, 16'h0001);
    wrap_up();
  end
endmodule // reset_and_interrupt_control_tb_top
